// [chan1_cfg_pkg.sv]
/*
  shared constants for the channel 1 level configuration registers:
  register addresses, field positions, reset values and code limits.
  assumes an 8-bit address and 8-bit data register port.
*/
package chan1_cfg_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] GAIN_CFG_ADDR   = 8'h3d;
  localparam logic [7:0] VOLUME_CFG_ADDR = 8'h3e;
  localparam logic [7:0] TRIM_CFG_ADDR   = 8'h3f;
  localparam logic [7:0] PHASE_CFG_ADDR  = 8'h40;

  // ==========================================================
  // reset values
  localparam logic [7:0] GAIN_CFG_RST   = 8'h00;
  localparam logic [7:0] VOLUME_CFG_RST = 8'hc9;
  localparam logic [7:0] TRIM_CFG_RST   = 8'h80;
  localparam logic [7:0] PHASE_CFG_RST  = 8'h00;

  // ==========================================================
  // field positions and masks
  localparam int         GAIN_LSB       = 2;
  localparam int         TRIM_LSB       = 4;
  localparam logic [7:0] GAIN_CFG_WMASK = 8'hfe;
  localparam logic [7:0] TRIM_CFG_WMASK = 8'hf0;

  // ==========================================================
  // code limits
  localparam logic [5:0] GAIN_MAX_CODE  = 6'h2a;
  localparam logic [7:0] VOLUME_MUTE    = 8'h00;

  // ==========================================================
  // apply state machine
  typedef enum logic [1:0] {
    APPLY_IDLE = 2'b00,
    APPLY_WAIT = 2'b01,
    APPLY_LOAD = 2'b11
  } apply_state_t;

endpackage

// [chan1_level_apply.sv]
/*
  moves register codes into the sample path two cycles after the next sample strobe.
  assumes i_sample_tick is a one-cycle pulse per sample period.
*/
module chan1_level_apply (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_sample_tick,
  input  wire logic       i_update,
  input  wire logic [5:0] i_gain,
  input  wire logic [7:0] i_volume,
  input  wire logic [3:0] i_trim,
  output logic      [5:0] o_gain,
  output logic      [7:0] o_volume,
  output logic            o_mute,
  output logic      [3:0] o_trim
);

  // ==========================================================
  // state
  chan1_cfg_pkg::apply_state_t state_r, state_nxt;
  logic [5:0] gain_r, gain_nxt;
  logic [7:0] vol_r, vol_nxt;
  logic [3:0] trim_r, trim_nxt;
  logic       mute_r, mute_nxt;

  always_comb begin
    state_nxt = state_r;
    gain_nxt  = gain_r;
    vol_nxt   = vol_r;
    trim_nxt  = trim_r;
    mute_nxt  = mute_r;
    case (state_r)
      chan1_cfg_pkg::APPLY_IDLE: begin
        if (i_update) begin
          state_nxt = chan1_cfg_pkg::APPLY_WAIT;
        end
      end
      chan1_cfg_pkg::APPLY_WAIT: begin
        if (i_sample_tick) begin
          state_nxt = chan1_cfg_pkg::APPLY_LOAD;
        end
      end
      chan1_cfg_pkg::APPLY_LOAD: begin
        // codes latched in the cycle after the sample tick
        gain_nxt  = i_gain;
        vol_nxt   = i_volume;
        trim_nxt  = i_trim;
        mute_nxt  = (i_volume == chan1_cfg_pkg::VOLUME_MUTE);
        state_nxt = i_update ? chan1_cfg_pkg::APPLY_WAIT : chan1_cfg_pkg::APPLY_IDLE;
      end
      default: begin
        state_nxt = chan1_cfg_pkg::APPLY_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= chan1_cfg_pkg::APPLY_IDLE;
      gain_r  <= chan1_cfg_pkg::GAIN_CFG_RST[7:2];
      vol_r   <= chan1_cfg_pkg::VOLUME_CFG_RST;
      trim_r  <= chan1_cfg_pkg::TRIM_CFG_RST[7:4];
      mute_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gain_r  <= gain_nxt;
      vol_r   <= vol_nxt;
      trim_r  <= trim_nxt;
      mute_r  <= mute_nxt;
    end
  end

  assign o_gain   = gain_r;
  assign o_volume = vol_r;
  assign o_mute   = mute_r;
  assign o_trim   = trim_r;

  // ==========================================================
  // checks
  a_mute_follows_code: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == chan1_cfg_pkg::APPLY_LOAD) |=>
      (o_mute == (o_volume == chan1_cfg_pkg::VOLUME_MUTE)))
    else $error("mute does not match volume code");

  a_tick_loads_codes: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == chan1_cfg_pkg::APPLY_WAIT && i_sample_tick) ##1 1'b1 |=>
      (o_gain == $past(i_gain) && o_trim == $past(i_trim)))
    else $error("codes not applied after sample tick");

endmodule

// [chan1_level_cfg_regs.sv]
/*
  channel 1 level configuration register bank: analog gain, digital
  volume, gain trim and phase trim registers on the device control port.
  assumes a synchronous 8-bit address/data port with write and read
  strobes, and a sample strobe from the converter timing.
*/
// Behaviour
// - gain field bits 7..2 selects analog gain equal to its code in dB.
// - gain register resets to zero, giving 0 dB.
// - volume code zero mutes the digital output.
// - volume codes 1..255 span -100 dB to +27 dB in half-dB steps.
// - volume resets to code 201, unity.
// - trim bits 7..4 steps 0.1 dB, -0.8 to +0.7, resets to code 8.
// - trim register bits 3..0 read zero; software writes zeros there.
module chan1_level_cfg_regs (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_rd,
  input  wire logic       i_sample_tick,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  output logic      [5:0] o_chan1_analog_gain,
  output logic      [7:0] o_chan1_digital_volume,
  output logic            o_chan1_mute,
  output logic      [3:0] o_chan1_gain_trim,
  output logic      [7:0] o_chan1_phase_trim
);

  // ==========================================================
  // read decode
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] g,
                                          input logic [7:0] v,
                                          input logic [7:0] t,
                                          input logic [7:0] p);
    logic [7:0] r;
    r = 8'h00;
    case (addr)
      chan1_cfg_pkg::GAIN_CFG_ADDR:   r = g & chan1_cfg_pkg::GAIN_CFG_WMASK;
      chan1_cfg_pkg::VOLUME_CFG_ADDR: r = v;
      chan1_cfg_pkg::TRIM_CFG_ADDR:   r = t & chan1_cfg_pkg::TRIM_CFG_WMASK;
      chan1_cfg_pkg::PHASE_CFG_ADDR:  r = p;
      default:                        r = 8'h00;
    endcase
    return r;
  endfunction

  // ==========================================================
  // register state
  logic [7:0] gain_cfg_r, gain_cfg_nxt;
  logic [7:0] vol_cfg_r, vol_cfg_nxt;
  logic [7:0] trim_cfg_r, trim_cfg_nxt;
  logic [7:0] phase_cfg_r, phase_cfg_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;
  logic       update_r, update_nxt;

  always_comb begin
    gain_cfg_nxt  = gain_cfg_r;
    vol_cfg_nxt   = vol_cfg_r;
    trim_cfg_nxt  = trim_cfg_r;
    phase_cfg_nxt = phase_cfg_r;
    update_nxt    = 1'b0;
    if (i_wr) begin
      case (i_addr)
        chan1_cfg_pkg::GAIN_CFG_ADDR: begin
          // bit 0 held at zero, bit 1 stored
          gain_cfg_nxt = i_wdata & chan1_cfg_pkg::GAIN_CFG_WMASK;
          update_nxt   = 1'b1;
        end
        chan1_cfg_pkg::VOLUME_CFG_ADDR: begin
          vol_cfg_nxt = i_wdata;
          update_nxt  = 1'b1;
        end
        chan1_cfg_pkg::TRIM_CFG_ADDR: begin
          trim_cfg_nxt = i_wdata & chan1_cfg_pkg::TRIM_CFG_WMASK;
          update_nxt   = 1'b1;
        end
        chan1_cfg_pkg::PHASE_CFG_ADDR: begin
          phase_cfg_nxt = i_wdata;
        end
        default: begin
          update_nxt = 1'b0;
        end
      endcase
    end
    rvalid_nxt = i_rd;
    rdata_nxt  = i_rd ? read_mux(i_addr, gain_cfg_r, vol_cfg_r, trim_cfg_r, phase_cfg_r)
                      : 8'h00;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gain_cfg_r  <= chan1_cfg_pkg::GAIN_CFG_RST;
      vol_cfg_r   <= chan1_cfg_pkg::VOLUME_CFG_RST;
      trim_cfg_r  <= chan1_cfg_pkg::TRIM_CFG_RST;
      phase_cfg_r <= chan1_cfg_pkg::PHASE_CFG_RST;
      rdata_r     <= 8'h00;
      rvalid_r    <= 1'b0;
      update_r    <= 1'b0;
    end else begin
      gain_cfg_r  <= gain_cfg_nxt;
      vol_cfg_r   <= vol_cfg_nxt;
      trim_cfg_r  <= trim_cfg_nxt;
      phase_cfg_r <= phase_cfg_nxt;
      rdata_r     <= rdata_nxt;
      rvalid_r    <= rvalid_nxt;
      update_r    <= update_nxt;
    end
  end

  assign o_rdata            = rdata_r;
  assign o_rvalid           = rvalid_r;
  assign o_chan1_phase_trim = phase_cfg_r;

  // ==========================================================
  // sample path hand-off
  chan1_level_apply u_apply (
    .i_mclk        (i_mclk),
    .i_reset       (i_reset),
    .i_sample_tick (i_sample_tick),
    .i_update      (update_r),
    .i_gain        (gain_cfg_r[7:chan1_cfg_pkg::GAIN_LSB]),
    .i_volume      (vol_cfg_r),
    .i_trim        (trim_cfg_r[7:chan1_cfg_pkg::TRIM_LSB]),
    .o_gain        (o_chan1_analog_gain),
    .o_volume      (o_chan1_digital_volume),
    .o_mute        (o_chan1_mute),
    .o_trim        (o_chan1_gain_trim)
  );

  // ==========================================================
  // checks
  a_gain_bit0_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_rd && i_addr == chan1_cfg_pkg::GAIN_CFG_ADDR) |=> (o_rvalid && o_rdata[0] == 1'b0))
    else $error("gain register bit 0 read nonzero");

  a_trim_low_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_rd && i_addr == chan1_cfg_pkg::TRIM_CFG_ADDR) |=> (o_rdata[3:0] == 4'h0))
    else $error("trim register low bits read nonzero");

  a_gain_reset_zero: assert property (@(posedge i_mclk)
    $past(i_reset) |-> (gain_cfg_r == 8'h00 && o_chan1_analog_gain == 6'h00))
    else $error("gain not zero after reset");

  a_volume_reset_unity: assert property (@(posedge i_mclk)
    $past(i_reset) |-> (vol_cfg_r == 8'hc9 && o_chan1_digital_volume == 8'hc9))
    else $error("volume not unity after reset");

  a_trim_reset_mid: assert property (@(posedge i_mclk)
    $past(i_reset) |-> (trim_cfg_r == 8'h80 && o_chan1_gain_trim == 4'h8))
    else $error("trim not mid code after reset");

  a_gain_write_reads: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_wr && i_addr == chan1_cfg_pkg::GAIN_CFG_ADDR) |=>
      (gain_cfg_r[7:2] == $past(i_wdata[7:2])))
    else $error("gain field not stored");

  a_bit0_stored_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_wr && i_addr == chan1_cfg_pkg::GAIN_CFG_ADDR) |=> (gain_cfg_r[0] == 1'b0))
    else $error("gain register bit 0 stored nonzero");

  a_volume_write_reads: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_wr && i_addr == chan1_cfg_pkg::VOLUME_CFG_ADDR) |=> (vol_cfg_r == $past(i_wdata)))
    else $error("volume code not stored");

  a_mute_on_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
    (o_chan1_digital_volume == 8'h00) |-> o_chan1_mute)
    else $error("zero volume code not muted");

  a_trim_write_reads: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_wr && i_addr == chan1_cfg_pkg::TRIM_CFG_ADDR) |=>
      (trim_cfg_r == {$past(i_wdata[7:4]), 4'h0}))
    else $error("trim code not stored");

  a_trim_low_held: assert property (@(posedge i_mclk) disable iff (i_reset)
    (trim_cfg_r[3:0] == 4'h0))
    else $error("trim register low bits hold nonzero");

  a_gain_read_back: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_rd && i_addr == chan1_cfg_pkg::GAIN_CFG_ADDR) |=>
      (o_rdata[7:1] == $past(gain_cfg_r[7:1])))
    else $error("gain register read back wrong");

  a_volume_read_back: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_rd && i_addr == chan1_cfg_pkg::VOLUME_CFG_ADDR) |=> (o_rdata == $past(vol_cfg_r)))
    else $error("volume register read back wrong");

  a_trim_read_back: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_rd && i_addr == chan1_cfg_pkg::TRIM_CFG_ADDR) |=>
      (o_rdata[7:4] == $past(trim_cfg_r[7:4])))
    else $error("trim register read back wrong");

  a_mute_off_nonzero: assert property (@(posedge i_mclk) disable iff (i_reset)
    (o_chan1_digital_volume != 8'h00) |-> !o_chan1_mute)
    else $error("nonzero volume code muted");

  // ==========================================================
  // applied path checks
  a_write_arms_update: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_wr && (i_addr == chan1_cfg_pkg::GAIN_CFG_ADDR ||
              i_addr == chan1_cfg_pkg::VOLUME_CFG_ADDR ||
              i_addr == chan1_cfg_pkg::TRIM_CFG_ADDR)) |=> update_r)
    else $error("register write did not arm an update");

  a_tick_syncs_path: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_sample_tick && !update_r && !i_wr) ##1 !i_wr |=>
      (o_chan1_analog_gain == gain_cfg_r[7:chan1_cfg_pkg::GAIN_LSB] &&
       o_chan1_digital_volume == vol_cfg_r &&
       o_chan1_gain_trim == trim_cfg_r[7:chan1_cfg_pkg::TRIM_LSB]))
    else $error("applied codes differ from registers after tick");

  a_change_after_tick: assert property (@(posedge i_mclk) disable iff (i_reset)
    ($changed(o_chan1_analog_gain) || $changed(o_chan1_digital_volume) ||
     $changed(o_chan1_gain_trim)) |-> $past(i_sample_tick, 2))
    else $error("applied codes changed without a sample tick");

endmodule

// [chan1_level_cfg_regs_tb_top.sv]
/*
  self-checking bench for the channel 1 level configuration registers.
  assumes the register bank is the only module driven, with a single
  100 MHz clock and synchronous active-high reset.
*/
module chan1_level_cfg_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals and model
  logic       i_mclk;
  logic       i_reset;
  logic [7:0] i_addr;
  logic       i_wr;
  logic [7:0] i_wdata;
  logic       i_rd;
  logic       i_sample_tick;
  logic [7:0] o_rdata;
  logic       o_rvalid;
  logic [5:0] o_chan1_analog_gain;
  logic [7:0] o_chan1_digital_volume;
  logic       o_chan1_mute;
  logic [3:0] o_chan1_gain_trim;
  logic [7:0] o_chan1_phase_trim;
  int         num_errors;
  int         cmp_count;
  logic [7:0] m_reg [4];
  logic [7:0] m_app [3];
  logic [5:0] g;
  logic [7:0] v;
  logic [3:0] t;

  chan1_level_cfg_regs DUT (
    .i_mclk                 (i_mclk),
    .i_reset                (i_reset),
    .i_addr                 (i_addr),
    .i_wr                   (i_wr),
    .i_wdata                (i_wdata),
    .i_rd                   (i_rd),
    .i_sample_tick          (i_sample_tick),
    .o_rdata                (o_rdata),
    .o_rvalid               (o_rvalid),
    .o_chan1_analog_gain    (o_chan1_analog_gain),
    .o_chan1_digital_volume (o_chan1_digital_volume),
    .o_chan1_mute           (o_chan1_mute),
    .o_chan1_gain_trim      (o_chan1_gain_trim),
    .o_chan1_phase_trim     (o_chan1_phase_trim)
  );

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= w;
    i_rd    <= r;
    i_addr  <= a;
    i_wdata <= d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    if (a == 8'h3d) m_reg[0] = d & 8'hfe;
    if (a == 8'h3e) m_reg[1] = d;
    if (a == 8'h3f) m_reg[2] = d & 8'hf0;
    if (a == 8'h40) m_reg[3] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    check({7'h00, o_rvalid}, 8'h01, "read answer");
    check(o_rdata, exp, "read data");
    @(posedge i_mclk);
    #1;
    check({7'h00, o_rvalid}, 8'h00, "read answer end");
    check(o_rdata, 8'h00, "read data end");
  endtask

  task automatic chk_app();
    check({2'b00, o_chan1_analog_gain}, m_app[0], "gain");
    check(o_chan1_digital_volume, m_app[1], "volume");
    check({7'h00, o_chan1_mute}, {7'h00, m_app[1] == 8'h00}, "mute");
    check({4'h0, o_chan1_gain_trim}, m_app[2], "trim");
  endtask

  task automatic tick();
    @(posedge i_mclk);
    i_sample_tick <= 1'b1;
    @(posedge i_mclk);
    i_sample_tick <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    m_app[0] = {2'b00, m_reg[0][7:2]};
    m_app[1] = m_reg[1];
    m_app[2] = {4'h0, m_reg[2][7:4]};
    chk_app();
  endtask

  task automatic do_reset();
    @(posedge i_mclk);
    i_reset <= 1'b1;
    i_wr    <= 1'b0;
    i_rd    <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    m_reg = '{8'h00, 8'hc9, 8'h80, 8'h00};
    m_app = '{8'h00, 8'hc9, 8'h08};
    #1;
    chk_app();
    for (int k = 0; k < 4; k++) rd(8'(8'h3d + k), m_reg[k]);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #500us;
    num_errors++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    i_reset = 1'b1;
    i_addr = 8'h00;
    i_wr = 1'b0;
    i_wdata = 8'h00;
    i_rd = 1'b0;
    i_sample_tick = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(75967));
    do_reset();
    $display("test reset values done");
    for (int i = 0; i < 14; i++) begin
      g = (i == 0) ? 6'h00 : (i == 1) ? 6'h2a : (i == 2) ? 6'h01 : 6'($urandom_range(42, 0));
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hff : 8'($urandom_range(255, 0));
      t = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom_range(15, 0));
      wr(8'h3e, ~v);
      wr(8'h3d, {g, 2'b00});
      wr(8'h3e, v);
      wr(8'h3f, {t, 4'h0});
      wr(8'h41, 8'($urandom_range(255, 0)));
      wr(8'h3c, 8'($urandom_range(255, 0)));
      wr(8'h40, 8'($urandom_range(255, 0)));
      repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      check(o_chan1_phase_trim, m_reg[3], "phase");
      chk_app();
      tick();
      for (int k = 0; k < 4; k++) rd(8'(8'h3d + k), m_reg[k]);
      rd(8'h41, 8'h00);
      rd(8'h3c, 8'h00);
    end
    $display("test code sweep done");
    wr(8'h3e, 8'h00);
    do_reset();
    tick();
    $display("test reset with pending update done");
    end_of_test();
  end
endmodule
